/* include/rcs_pkg.sv */
/*
 * Constants, types and mode encodings shared by the remote control
 * supervisor and its set-value clipping unit.
 * Assumes a single 40 MHz clock domain and a plain register port.
 */
// Summary of operation
// - supervise only the digital interface that currently holds remote control
// - supervision suspended whenever the device is not under remote control
// - every message on the supervised interface reloads the timer
// - on timer expiry the device leaves remote control
// - on expiry with output on, switch off or keep per configuration
// - a new timeout value applies only after the running period elapses
// - supervision is independent of the network connection timeout
// - analog control only after takeover pin asserts; inputs ignored before
// - output standby pin acts regardless of analog control state
// - voltage, current, power taken together from analog; resistance optional
// - protection thresholds are never taken from the analog interface
// - under analog control the displayed set values are the analog ones
// - analog range selectable as 0-5 V or 0-10 V full scale
// - reference output level follows the selected range
// - every set value is clipped to its adjustment limit
// - digital takeover refused with error while analog control active
package rcs_pkg;
   // ****************************************************************
   // register map (word addresses)
   // ****************************************************************
   localparam logic [3:0] ADDR_CTRL      = 4'h0;
   localparam logic [3:0] ADDR_TIMEOUT   = 4'h1;
   localparam logic [3:0] ADDR_STATUS    = 4'h2;
   localparam logic [3:0] ADDR_LIM_V     = 4'h3;
   localparam logic [3:0] ADDR_LIM_I     = 4'h4;
   localparam logic [3:0] ADDR_LIM_P     = 4'h5;
   localparam logic [3:0] ADDR_LIM_R     = 4'h6;
   localparam logic [3:0] ADDR_OVP       = 4'h7;
   localparam logic [3:0] ADDR_PANEL_V   = 4'h8;
   localparam logic [3:0] ADDR_PANEL_I   = 4'h9;
   localparam logic [3:0] ADDR_PANEL_P   = 4'hA;
   localparam logic [3:0] ADDR_PANEL_R   = 4'hB;
   localparam logic [3:0] ADDR_SHOW_V    = 4'hC;
   localparam logic [3:0] ADDR_SHOW_I    = 4'hD;
   localparam logic [3:0] ADDR_SHOW_P    = 4'hE;
   localparam logic [3:0] ADDR_SHOW_R    = 4'hF;

   // ****************************************************************
   // control register fields
   // ****************************************************************
   localparam int CTRL_SUPV_EN   = 0;
   localparam int CTRL_KEEP_ON   = 1;
   localparam int CTRL_RANGE10   = 2;
   localparam int CTRL_LOCAL     = 3;
   localparam int CTRL_OUT_ON    = 4;
   localparam int CTRL_RES_MODE  = 5;
   localparam int CTRL_WIDTH     = 6;
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 6'h00;

   // ****************************************************************
   // status register fields
   // ****************************************************************
   localparam int ST_REMOTE_DIG  = 0;
   localparam int ST_REMOTE_ANA  = 1;
   localparam int ST_OUT_ON      = 2;
   localparam int ST_EXPIRED     = 3;
   localparam int ST_REJECTED    = 4;
   localparam int ST_IF_LSB      = 8;

   // ****************************************************************
   // timing: timeout counted in milliseconds
   // ****************************************************************
   localparam int  CLK_HZ         = 40_000_000;
   localparam int  TICK_MS        = 1;
   localparam int  TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
   localparam logic [15:0] TIMEOUT_RESET = 16'h03E8;

   // ****************************************************************
   // analog scaling: 0-5 V full scale reads half of 0-10 V full scale
   // ****************************************************************
   localparam int  SCALE_SHIFT_5V = 1;
   localparam int  REF_MV_5       = 5000;
   localparam int  REF_MV_10      = 10000;

   // digital interface identifiers
   localparam int  IF_ID_W        = 3;
   localparam logic [IF_ID_W-1:0] IF_NONE = 3'h0;

   typedef enum {CTL_MANUAL, CTL_DIGITAL, CTL_ANALOG} rcs_ctl_type;
endpackage

/* include/rcs_lim_if.sv */
/*
 * Carries one raw set value and its limit to the clipping unit and
 * the clipped result back. Used only between the supervisor modules.
 */
interface rcs_lim_if #(parameter int W = 16);
   logic [W-1:0] raw;
   logic [W-1:0] limit;
   logic [W-1:0] clipped;
   modport src (output raw, output limit, input clipped);
   modport clip (input raw, input limit, output clipped);
endinterface

/* src/rcs_clip.sv */
/*
 * Clips four set values against their adjustment limits.
 * Assumes the caller presents values already scaled to full width.
 */
module rcs_clip #(
   parameter int N = 4
) (
   rcs_lim_if.clip lanes [N]
);
   for (genvar k = 0; k < N; k++) begin : g_lane
      assign lanes[k].clipped = (lanes[k].raw > lanes[k].limit) ?
                                lanes[k].limit : lanes[k].raw;
   end
endmodule

/* src/rcs_supervisor.sv */
/*
 * Remote control supervisor: arbitrates digital and analog remote
 * control, runs the communication watchdog on the controlling digital
 * interface, scales and clips set values and drives the reference level.
 * Assumes frame-ok strobes come from same-clock protocol logic; the two
 * analog-side control pins are asynchronous and are synchronised here.
 */
// Strobed register access and the placing of the registers were chosen for this implementation.
module rcs_supervisor #(
   parameter int W       = 16,
   parameter int TICKS   = rcs_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic                      clkEn,
   // register port
   input  wire logic [3:0]                regAddr,
   input  wire logic [31:0]               regWrData,
   input  wire logic                      regWr,
   input  wire logic                      regRd,
   output logic [31:0]                    regRdData,
   // digital interfaces (same clock)
   input  wire logic                      remoteReq,
   input  wire logic                      remoteRelease,
   input  wire logic [rcs_pkg::IF_ID_W-1:0] reqIf,
   input  wire logic                      frameOk,
   input  wire logic [rcs_pkg::IF_ID_W-1:0] frameIf,
   output logic                           remoteErr,
   output logic [rcs_pkg::IF_ID_W-1:0]    remoteErrIf,
   // analog port pins
   input  wire logic                      analogTakeover_n,
   input  wire logic                      outputStandbyPin,
   input  wire logic [W-1:0]              voltageSetpointInput,
   input  wire logic [W-1:0]              currentSetpointInput,
   input  wire logic [W-1:0]              powerSetpointInput,
   input  wire logic [W-1:0]              resistanceSetpointInput,
   output logic                           refHigh,
   // applied results
   output logic [W-1:0]                   setV,
   output logic [W-1:0]                   setI,
   output logic [W-1:0]                   setP,
   output logic [W-1:0]                   setR,
   output logic [W-1:0]                   ovpLevel,
   output logic                           dcOutputOn
);
   // ****************************************************************
   // functions
   // ****************************************************************
   function automatic logic [W-1:0] scaleIn(input logic [W-1:0] v, input logic r10);
      // full-width code means 100 %; the 5 V span delivers half the code
      logic [W:0] t;
      t = {1'b0, v} << rcs_pkg::SCALE_SHIFT_5V;
      if (r10)
         scaleIn = v;
      else if (t[W])
         scaleIn = '1;
      else
         scaleIn = t[W-1:0];
   endfunction

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [1:0] takeSync_ff, nxt_takeSync;
   logic [1:0] sbSync_ff,   nxt_sbSync;
   logic       analogPin;
   logic       standbyOn;

   always_comb begin
      nxt_takeSync = {takeSync_ff[0], ~analogTakeover_n};
      nxt_sbSync   = {sbSync_ff[0], outputStandbyPin};
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         takeSync_ff <= 2'h0;
         sbSync_ff   <= 2'h3;
      end else if (clkEn) begin
         takeSync_ff <= nxt_takeSync;
         sbSync_ff   <= nxt_sbSync;
      end
   end

   assign analogPin = takeSync_ff[1];
   assign standbyOn = sbSync_ff[1];

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   logic [rcs_pkg::CTRL_WIDTH-1:0] ctrl_ff, nxt_ctrl;
   logic [15:0] timeoutCfg_ff, nxt_timeoutCfg;
   logic [W-1:0] limV_ff, limI_ff, limP_ff, limR_ff, ovp_ff;
   logic [W-1:0] nxt_limV, nxt_limI, nxt_limP, nxt_limR, nxt_ovp;
   logic [W-1:0] panV_ff, panI_ff, panP_ff, panR_ff;
   logic [W-1:0] nxt_panV, nxt_panI, nxt_panP, nxt_panR;
   logic         outOnClr;

   always_comb begin
      nxt_ctrl       = ctrl_ff;
      nxt_timeoutCfg = timeoutCfg_ff;
      nxt_limV = limV_ff;
      nxt_limI = limI_ff;
      nxt_limP = limP_ff;
      nxt_limR = limR_ff;
      nxt_ovp  = ovp_ff;
      nxt_panV = panV_ff;
      nxt_panI = panI_ff;
      nxt_panP = panP_ff;
      nxt_panR = panR_ff;
      if (regWr) begin
         case (regAddr)
            rcs_pkg::ADDR_CTRL:    nxt_ctrl = regWrData[rcs_pkg::CTRL_WIDTH-1:0];
            rcs_pkg::ADDR_TIMEOUT: nxt_timeoutCfg = regWrData[15:0];
            rcs_pkg::ADDR_LIM_V:   nxt_limV = regWrData[W-1:0];
            rcs_pkg::ADDR_LIM_I:   nxt_limI = regWrData[W-1:0];
            rcs_pkg::ADDR_LIM_P:   nxt_limP = regWrData[W-1:0];
            rcs_pkg::ADDR_LIM_R:   nxt_limR = regWrData[W-1:0];
            rcs_pkg::ADDR_OVP:     nxt_ovp  = regWrData[W-1:0];
            rcs_pkg::ADDR_PANEL_V: nxt_panV = regWrData[W-1:0];
            rcs_pkg::ADDR_PANEL_I: nxt_panI = regWrData[W-1:0];
            rcs_pkg::ADDR_PANEL_P: nxt_panP = regWrData[W-1:0];
            rcs_pkg::ADDR_PANEL_R: nxt_panR = regWrData[W-1:0];
            default: ;
         endcase
      end
      // expiry with switch-off wins over a same-cycle software write
      if (outOnClr)
         nxt_ctrl[rcs_pkg::CTRL_OUT_ON] = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_ff       <= rcs_pkg::CTRL_RESET;
         timeoutCfg_ff <= rcs_pkg::TIMEOUT_RESET;
         limV_ff <= '1;
         limI_ff <= '1;
         limP_ff <= '1;
         limR_ff <= '1;
         ovp_ff  <= '1;
         panV_ff <= '0;
         panI_ff <= '0;
         panP_ff <= '0;
         panR_ff <= '0;
      end else if (clkEn) begin
         ctrl_ff       <= nxt_ctrl;
         timeoutCfg_ff <= nxt_timeoutCfg;
         limV_ff <= nxt_limV;
         limI_ff <= nxt_limI;
         limP_ff <= nxt_limP;
         limR_ff <= nxt_limR;
         ovp_ff  <= nxt_ovp;
         panV_ff <= nxt_panV;
         panI_ff <= nxt_panI;
         panP_ff <= nxt_panP;
         panR_ff <= nxt_panR;
      end
   end

   // ****************************************************************
   // control location and watchdog
   // ****************************************************************
   rcs_pkg::rcs_ctl_type ctl_ff, nxt_ctl;
   logic [rcs_pkg::IF_ID_W-1:0] ownIf_ff, nxt_ownIf;
   logic [15:0] msLeft_ff, nxt_msLeft;
   logic [15:0] period_ff, nxt_period;
   logic [$clog2(TICKS+1)-1:0] tick_ff, nxt_tick;
   logic expired_ff, nxt_expired;
   logic rejected_ff, nxt_rejected;
   logic errPulse_ff, nxt_errPulse;
   logic [rcs_pkg::IF_ID_W-1:0] errIf_ff, nxt_errIf;
   logic supvRun, ownFrame, timeUp;

   // network connection timeout is handled elsewhere and untouched here
   assign supvRun  = (ctl_ff == rcs_pkg::CTL_DIGITAL) &&
                     ctrl_ff[rcs_pkg::CTRL_SUPV_EN];
   assign ownFrame = frameOk && (frameIf == ownIf_ff);
   assign timeUp   = supvRun && (msLeft_ff == 16'h0000) &&
                     (tick_ff == '0) && !ownFrame;
   assign outOnClr = timeUp && !ctrl_ff[rcs_pkg::CTRL_KEEP_ON];

   always_comb begin
      nxt_ctl      = ctl_ff;
      nxt_ownIf    = ownIf_ff;
      nxt_msLeft   = msLeft_ff;
      nxt_period   = period_ff;
      nxt_tick     = tick_ff;
      nxt_expired  = expired_ff;
      nxt_rejected = rejected_ff;
      nxt_errPulse = 1'b0;
      nxt_errIf    = errIf_ff;
      if (regWr && regAddr == rcs_pkg::ADDR_STATUS) begin
         nxt_expired  = expired_ff  & ~regWrData[rcs_pkg::ST_EXPIRED];
         nxt_rejected = rejected_ff & ~regWrData[rcs_pkg::ST_REJECTED];
      end
      case (ctl_ff)
         rcs_pkg::CTL_MANUAL: begin
            if (ctrl_ff[rcs_pkg::CTRL_LOCAL]) begin
               nxt_ctl = rcs_pkg::CTL_MANUAL;
            end else if (analogPin) begin
               nxt_ctl = rcs_pkg::CTL_ANALOG;
            end else if (remoteReq && reqIf != rcs_pkg::IF_NONE) begin
               nxt_ctl    = rcs_pkg::CTL_DIGITAL;
               nxt_ownIf  = reqIf;
               nxt_period = timeoutCfg_ff;
               nxt_msLeft = timeoutCfg_ff;
               nxt_tick   = TICKS[$bits(nxt_tick)-1:0] - 1'b1;
            end
         end
         rcs_pkg::CTL_DIGITAL: begin
            if (ctrl_ff[rcs_pkg::CTRL_LOCAL] ||
                (remoteRelease && reqIf == ownIf_ff)) begin
               nxt_ctl   = rcs_pkg::CTL_MANUAL;
               nxt_ownIf = rcs_pkg::IF_NONE;
            end else if (supvRun) begin
               if (ownFrame) begin
                  nxt_msLeft = period_ff;
                  nxt_tick   = TICKS[$bits(nxt_tick)-1:0] - 1'b1;
               end else if (timeUp) begin
                  nxt_ctl     = rcs_pkg::CTL_MANUAL;
                  nxt_ownIf   = rcs_pkg::IF_NONE;
                  nxt_expired = 1'b1;
               end else if (tick_ff == '0) begin
                  nxt_tick   = TICKS[$bits(nxt_tick)-1:0] - 1'b1;
                  nxt_msLeft = msLeft_ff - 16'h0001;
                  if (msLeft_ff == 16'h0001)
                     nxt_period = timeoutCfg_ff;
               end else begin
                  nxt_tick = tick_ff - 1'b1;
               end
            end else begin
               nxt_period = timeoutCfg_ff;
               nxt_msLeft = timeoutCfg_ff;
            end
         end
         rcs_pkg::CTL_ANALOG: begin
            if (!analogPin)
               nxt_ctl = rcs_pkg::CTL_MANUAL;
            if (remoteReq) begin
               nxt_rejected = 1'b1;
               nxt_errPulse = 1'b1;
               nxt_errIf    = reqIf;
            end
         end
         default: nxt_ctl = rcs_pkg::CTL_MANUAL;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctl_ff      <= rcs_pkg::CTL_MANUAL;
         ownIf_ff    <= rcs_pkg::IF_NONE;
         msLeft_ff   <= rcs_pkg::TIMEOUT_RESET;
         period_ff   <= rcs_pkg::TIMEOUT_RESET;
         tick_ff     <= '0;
         expired_ff  <= 1'b0;
         rejected_ff <= 1'b0;
         errPulse_ff <= 1'b0;
         errIf_ff    <= rcs_pkg::IF_NONE;
      end else if (clkEn) begin
         ctl_ff      <= nxt_ctl;
         ownIf_ff    <= nxt_ownIf;
         msLeft_ff   <= nxt_msLeft;
         period_ff   <= nxt_period;
         tick_ff     <= nxt_tick;
         expired_ff  <= nxt_expired;
         rejected_ff <= nxt_rejected;
         errPulse_ff <= nxt_errPulse;
         errIf_ff    <= nxt_errIf;
      end
   end

   assign remoteErr   = errPulse_ff;
   assign remoteErrIf = errIf_ff;

   // ****************************************************************
   // set value selection, scaling and clipping
   // ****************************************************************
   rcs_lim_if #(.W(W)) lanes [4] ();
   logic anaOn, r10;
   logic [W-1:0] sv_ff [4];
   logic [W-1:0] nxt_sv [4];
   logic dcOn_ff, nxt_dcOn;

   assign anaOn = (ctl_ff == rcs_pkg::CTL_ANALOG) && !ctrl_ff[rcs_pkg::CTRL_LOCAL];
   assign r10   = ctrl_ff[rcs_pkg::CTRL_RANGE10];

   // all three main set values switch source together
   assign lanes[0].raw = anaOn ? scaleIn(voltageSetpointInput, r10) : panV_ff;
   assign lanes[1].raw = anaOn ? scaleIn(currentSetpointInput, r10) : panI_ff;
   assign lanes[2].raw = anaOn ? scaleIn(powerSetpointInput, r10)   : panP_ff;
   assign lanes[3].raw = (anaOn && ctrl_ff[rcs_pkg::CTRL_RES_MODE]) ?
                         scaleIn(resistanceSetpointInput, r10) : panR_ff;
   assign lanes[0].limit = limV_ff;
   assign lanes[1].limit = limI_ff;
   assign lanes[2].limit = limP_ff;
   assign lanes[3].limit = limR_ff;

   rcs_clip #(.N(4)) u_clip (
      .lanes (lanes)
   );

   always_comb begin
      nxt_sv[0] = lanes[0].clipped;
      nxt_sv[1] = lanes[1].clipped;
      nxt_sv[2] = lanes[2].clipped;
      nxt_sv[3] = lanes[3].clipped;
      // standby pin gates the output in every control location
      nxt_dcOn  = nxt_ctrl[rcs_pkg::CTRL_OUT_ON] && standbyOn;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int k = 0; k < 4; k++)
            sv_ff[k] <= '0;
         dcOn_ff <= 1'b0;
      end else if (clkEn) begin
         for (int k = 0; k < 4; k++)
            sv_ff[k] <= nxt_sv[k];
         dcOn_ff <= nxt_dcOn;
      end
   end

   assign setV       = sv_ff[0];
   assign setI       = sv_ff[1];
   assign setP       = sv_ff[2];
   assign setR       = sv_ff[3];
   assign ovpLevel   = ovp_ff;
   assign dcOutputOn = dcOn_ff;
   assign refHigh    = ctrl_ff[rcs_pkg::CTRL_RANGE10];

   // ****************************************************************
   // read port
   // ****************************************************************
   logic [31:0] rd_ff, nxt_rd;

   always_comb begin
      nxt_rd = 32'h0000_0000;
      if (regRd) begin
         case (regAddr)
            rcs_pkg::ADDR_CTRL:    nxt_rd[rcs_pkg::CTRL_WIDTH-1:0] = ctrl_ff;
            rcs_pkg::ADDR_TIMEOUT: nxt_rd[15:0] = timeoutCfg_ff;
            rcs_pkg::ADDR_STATUS: begin
               nxt_rd[rcs_pkg::ST_REMOTE_DIG] = (ctl_ff == rcs_pkg::CTL_DIGITAL);
               nxt_rd[rcs_pkg::ST_REMOTE_ANA] = anaOn;
               nxt_rd[rcs_pkg::ST_OUT_ON]     = dcOn_ff;
               nxt_rd[rcs_pkg::ST_EXPIRED]    = expired_ff;
               nxt_rd[rcs_pkg::ST_REJECTED]   = rejected_ff;
               nxt_rd[rcs_pkg::ST_IF_LSB +: rcs_pkg::IF_ID_W] = ownIf_ff;
            end
            rcs_pkg::ADDR_LIM_V:   nxt_rd[W-1:0] = limV_ff;
            rcs_pkg::ADDR_LIM_I:   nxt_rd[W-1:0] = limI_ff;
            rcs_pkg::ADDR_LIM_P:   nxt_rd[W-1:0] = limP_ff;
            rcs_pkg::ADDR_LIM_R:   nxt_rd[W-1:0] = limR_ff;
            rcs_pkg::ADDR_OVP:     nxt_rd[W-1:0] = ovp_ff;
            rcs_pkg::ADDR_PANEL_V: nxt_rd[W-1:0] = panV_ff;
            rcs_pkg::ADDR_PANEL_I: nxt_rd[W-1:0] = panI_ff;
            rcs_pkg::ADDR_PANEL_P: nxt_rd[W-1:0] = panP_ff;
            rcs_pkg::ADDR_PANEL_R: nxt_rd[W-1:0] = panR_ff;
            rcs_pkg::ADDR_SHOW_V:  nxt_rd[W-1:0] = sv_ff[0];
            rcs_pkg::ADDR_SHOW_I:  nxt_rd[W-1:0] = sv_ff[1];
            rcs_pkg::ADDR_SHOW_P:  nxt_rd[W-1:0] = sv_ff[2];
            rcs_pkg::ADDR_SHOW_R:  nxt_rd[W-1:0] = sv_ff[3];
            default:               nxt_rd = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         rd_ff <= 32'h0000_0000;
      else if (clkEn)
         rd_ff <= nxt_rd;
   end

   assign regRdData = rd_ff;
endmodule

/* tb/rcs_supervisor_asserts.sv */
/*
 * Port assertions for the remote control supervisor.
 * Assumes clkEn drops only while the watched inputs hold still.
 */
module rcs_supervisor_asserts #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic         clk,
   input wire logic         rst_n,
   // register port
   input wire logic [3:0]   regAddr,
   input wire logic [31:0]  regWrData,
   input wire logic         regWr,
   // remote control
   input wire logic         remoteReq,
   input wire logic [2:0]   reqIf,
   input wire logic         remoteErr,
   input wire logic [2:0]   remoteErrIf,
   // analog port and results
   input wire logic         analogTakeover_n,
   input wire logic         outputStandbyPin,
   input wire logic         refHigh,
   input wire logic [W-1:0] setV,
   input wire logic [W-1:0] ovpLevel,
   input wire logic         dcOutputOn
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ****
   // remote control and analog port
   // ****
   a_err_cause:
      assert property (remoteErr |-> $past(remoteReq))
      else $error("remote error without a request");
   a_err_ident:
      assert property (remoteErr |-> remoteErrIf == $past(reqIf))
      else $error("remote error names the wrong interface");
   a_ovp_held:
      assert property (!($past(regWr) && $past(regAddr) == rcs_pkg::ADDR_OVP)
         |-> $stable(ovpLevel))
      else $error("protection level moved without a write");
   a_ref_follow:
      assert property (regWr && regAddr == rcs_pkg::ADDR_CTRL
         |=> refHigh == $past(regWrData[rcs_pkg::CTRL_RANGE10]))
      else $error("reference level does not follow the range");
   a_ref_steady:
      assert property (!(regWr && regAddr == rcs_pkg::ADDR_CTRL) |=> $stable(refHigh))
      else $error("reference level moved without a write");
   a_standby_off:
      assert property (!outputStandbyPin [*3] |=> !dcOutputOn)
      else $error("output stays on after standby");
   a_on_needs_pin:
      assert property (dcOutputOn |-> $past(outputStandbyPin, 3))
      else $error("output on while standby pin low");
   a_set_quiet:
      assert property ((analogTakeover_n && !regWr) [*8] |=> $stable(setV))
      else $error("set value moved outside analog control");
endmodule
bind rcs_supervisor rcs_supervisor_asserts #(.W(W)) rcs_supervisor_asserts_i (
   .clk, .rst_n, .regAddr, .regWrData, .regWr, .remoteReq, .reqIf, .remoteErr,
   .remoteErrIf, .analogTakeover_n, .outputStandbyPin, .refHigh, .setV, .ovpLevel,
   .dcOutputOn
);

/* tb/rcs_host_model.sv */
/*
 * Controlling host: one command frame pulse every gap cycles on id.
 * Assumes the bench sets id and enable after a clock edge.
 */
module rcs_host_model (
   // clock and reset
   input wire logic  clk,
   input wire logic  rst_n,
   // control from the bench
   input wire logic       en,
   input wire logic [2:0] id,
   input wire logic [31:0] gap,
   // frame strobes
   output logic       frameOk,
   output logic [2:0] frameIf = 3'h5
);
   timeunit 1ns;
   timeprecision 100ps;
   int   cnt = 0;
   logic fire;
   assign fire = rst_n && en && cnt >= gap - 1;
   // frame id is meaningless between frames, so it keeps toggling
   always @(posedge clk) begin
      cnt <= fire || !en ? 0 : cnt + 1;
      frameOk <= fire;
      frameIf <= fire ? id : ~frameIf;
   end
endmodule

/* tb/tb_rcs_supervisor.sv */
/*
 * Self-checking bench for the remote control supervisor.
 * Assumes a tick of 4 cycles so the timeouts stay short.
 */
module tb_rcs_supervisor;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0;
   logic [31:0] regRdData, rd;
   logic        regWr = 1'b0, regRd = 1'b0, remoteReq = 1'b0, remoteRelease = 1'b0;
   logic [2:0]  reqIf = 3'h0, hostId = 3'h2, frameIf, remoteErrIf;
   logic        hostEn = 1'b0, frameOk, remoteErr, refHigh, dcOutputOn;
   logic        analogTakeover_n = 1'b1, outputStandbyPin = 1'b1, clkEn = 1'b1;
   logic [15:0] voltageSetpointInput = 16'h0, currentSetpointInput = 16'h0;
   logic [15:0] powerSetpointInput = 16'h0, resistanceSetpointInput = 16'h1800;
   logic [15:0] setV, setI, setP, setR, ovpLevel;
   int          err_total = 0, n_checks = 0, cyc = 0;
   rcs_supervisor #(.W(16), .TICKS(4)) rcs_supervisor_i (
      .clk, .rst_n, .clkEn, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
      .remoteReq, .remoteRelease, .reqIf, .frameOk, .frameIf, .remoteErr, .remoteErrIf,
      .analogTakeover_n, .outputStandbyPin, .voltageSetpointInput, .currentSetpointInput,
      .powerSetpointInput, .resistanceSetpointInput, .refHigh, .setV, .setI, .setP,
      .setR, .ovpLevel, .dcOutputOn);
   rcs_host_model rcs_host_model_i (.clk, .rst_n, .en(hostEn), .id(hostId), .gap(12),
      .frameOk, .frameIf);
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         summarize();
      end
   end
   // ****
   // bus and compare helpers
   // ****
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rdr(logic [3:0] a);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      rd = regRdData;
      @(posedge clk);
   endtask
   task automatic pulse(logic rel, logic [2:0] id);
      @(posedge clk);
      remoteReq <= !rel;
      remoteRelease <= rel;
      reqIf <= id;
      @(posedge clk);
      remoteReq <= 1'b0;
      remoteRelease <= 1'b0;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_watch();
      rdr(rcs_pkg::ADDR_TIMEOUT);
      chk("timeout reset", rd, 32'(rcs_pkg::TIMEOUT_RESET));
      wr(rcs_pkg::ADDR_TIMEOUT, 32'h5);
      wr(rcs_pkg::ADDR_CTRL, 32'h11);
      pulse(1'b0, 3'h2);
      hostEn <= 1'b1;
      repeat (150) @(posedge clk);
      rdr(rcs_pkg::ADDR_STATUS);
      chk("status held", rd[10:0], 32'h205);
      hostId <= 3'h3;
      repeat (40) @(posedge clk);
      rdr(rcs_pkg::ADDR_STATUS);
      chk("status expired", rd[4:0], 32'h08);
      chk("output off", dcOutputOn, 1'b0);
      hostEn <= 1'b0;
      $display("watchdog test done");
   endtask
   task automatic t_keep();
      wr(rcs_pkg::ADDR_STATUS, 32'h18);
      wr(rcs_pkg::ADDR_CTRL, 32'h13);
      pulse(1'b0, 3'h1);
      pulse(1'b1, 3'h1);
      repeat (40) @(posedge clk);
      rdr(rcs_pkg::ADDR_STATUS);
      chk("status released", rd[4:0], 32'h04);
      pulse(1'b0, 3'h1);
      wr(rcs_pkg::ADDR_TIMEOUT, 32'hC8);
      repeat (40) @(posedge clk);
      rdr(rcs_pkg::ADDR_STATUS);
      chk("status kept on", rd[4:0], 32'h0C);
      chk("output kept", dcOutputOn, 1'b1);
      $display("keep-on test done");
   endtask
   task automatic t_analog();
      wr(rcs_pkg::ADDR_CTRL, 32'h14);
      wr(rcs_pkg::ADDR_LIM_V, 32'h8000);
      wr(rcs_pkg::ADDR_LIM_I, 32'hFFFF);
      wr(rcs_pkg::ADDR_LIM_P, 32'hFFFF);
      wr(rcs_pkg::ADDR_PANEL_V, 32'h1000);
      voltageSetpointInput <= 16'h2000;
      currentSetpointInput <= 16'h3000;
      powerSetpointInput <= 16'hA000;
      repeat (10) @(posedge clk);
      chk("panel V", setV, 16'h1000);
      analogTakeover_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk("analog V", setV, 16'h2000);
      chk("analog I", setI, 16'h3000);
      chk("analog P", setP, 16'hA000);
      rdr(rcs_pkg::ADDR_SHOW_V);
      chk("shown V", rd, 32'h2000);
      clkEn <= 1'b0;
      voltageSetpointInput <= 16'h9000;
      repeat (10) @(posedge clk);
      chk("frozen V", setV, 16'h2000);
      clkEn <= 1'b1;
      repeat (10) @(posedge clk);
      chk("clipped V", setV, 16'h8000);
      wr(rcs_pkg::ADDR_CTRL, 32'h30);
      voltageSetpointInput <= 16'h2000;
      repeat (10) @(posedge clk);
      chk("5V range V", setV, 16'h4000);
      chk("analog R", setR, 16'h3000);
      chk("reference", refHigh, 1'b0);
      chk("ovp level", ovpLevel, 16'hFFFF);
      pulse(1'b0, 3'h1);
      @(negedge clk);
      chk("takeover refused", {remoteErrIf, remoteErr}, 4'h3);
      @(posedge clk);
      outputStandbyPin <= 1'b0;
      repeat (5) @(posedge clk);
      chk("standby off", dcOutputOn, 1'b0);
      outputStandbyPin <= 1'b1;
      analogTakeover_n <= 1'b1;
      $display("analog test done");
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      // status outputs are not trusted until the start phase is over
      repeat (4) @(posedge clk);
      t_watch();
      t_keep();
      pulse(1'b1, 3'h1);
      t_analog();
      summarize();
   end
endmodule
